// ### sarp_pkg.sv
/*
  Shared constants and carrier types for the subranging sample pipeline.
  Assumes a single clock domain; the sample clock is a synchronous strobe.
*/
package sarp_pkg;
  // Field widths
  localparam int CODE_W   = 10;
  localparam int COARSE_W = 5;
  localparam int FINE_W   = 6;
  localparam int AIN_W    = 12;              // Digitised analog stand-in
  localparam int LAT      = 3;               // Pipeline edges to output
  localparam int FLUSH_EDGES = 4;            // Valid from this edge on
  localparam int FIFO_DEPTH  = 16;
  // Codes
  localparam logic [CODE_W-1:0] CODE_POS_FS = 10'h01FF;
  localparam logic [CODE_W-1:0] CODE_NEG_FS = 10'h0200;
  localparam logic [AIN_W-1:0]  AIN_POS_LIM = 12'h07FF;  // Top in-range input
  localparam logic [AIN_W-1:0]  AIN_NEG_LIM = 12'h0800;  // Bottom in-range input
  localparam logic [2:0]        FLUSH_CNT_W0 = 3'h0;
  localparam logic [2:0]        FLUSH_DONE   = 3'h4;
  // Timing
  localparam real CLK_NS      = 5.0;
  localparam real RECOVER_NS  = 3.0;
  localparam int  RECOVER_CYC = (RECOVER_NS / CLK_NS) < 1.0 ? 1 : int'(RECOVER_NS / CLK_NS);
  // Analog input sample; over/under mark overdrive beyond the nominal range
  typedef struct packed {
    logic signed [AIN_W-1:0] level;
    logic                    over;
    logic                    under;
  } sarp_ain_t;
  // One result word travelling down the pipeline
  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic              oor;
  } sarp_word_t;
endpackage

// ### sarp_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a clock enable that freezes it.
*/
`timescale 1ns/100ps
module sarp_fifo
  import sarp_pkg::*;
#(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } sarp_fifo_st_t;

  sarp_fifo_st_t st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  // Handshakes; honest full and empty come from the count
  assign in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data  = mem[st_reg.rp];
  assign push = ce && in_valid && in_ready;
  assign pop  = ce && out_valid && out_ready;

  // Pointer update
  always_comb begin
    st_next = st_reg;
    if (push) st_next.wp = st_reg.wp + 1'b1;
    if (pop)  st_next.rp = st_reg.rp + 1'b1;
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) st_reg <= '0;
    else     st_reg <= st_next;
  end

  // Storage has no reset; the count guards stale words
  always_ff @(posedge ref_clk) begin
    if (push) mem[st_reg.wp] <= in_data;
  end
endmodule

// ### sarp_top.sv
/*
  Digital side of a two-step subranging converter: coarse and fine
  estimates, overlap correction, saturation, three-edge latency, flush.
  Assumes the sample clock arrives as a synchronous rising-edge strobe.
*/
`timescale 1ns/100ps
module sarp_top
  import sarp_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              sample_edge,
  input  wire logic              clk_restart,
  input  wire sarp_ain_t         ain,
  output logic [CODE_W-1:0]      sample_code_bits,
  output logic                   out_of_range,
  output logic                   code_valid,
  output sarp_word_t             fifo_word,
  output logic                   fifo_valid,
  input  wire logic              fifo_ready,
  output logic                   fifo_overflow
);
  typedef struct packed {
    sarp_ain_t         held;
    logic              s1_v;
    logic [COARSE_W-1:0] coarse;
    logic [FINE_W-1:0] fine;
    logic              s1_over;
    logic              s1_under;
    sarp_word_t        s2;
    sarp_word_t        outw;
    logic [2:0]        flush;
    logic              valid;
    logic              push;
    logic              ovf;
  } sarp_st_t;

  sarp_st_t st_reg, st_next;
  logic in_ready;
  sarp_word_t f_data;
  logic f_valid;
  logic signed [AIN_W-1:0] residue;
  logic [CODE_W:0] merged;

  ////////////////////////////////////////////////////////////////////////
  // Coarse reconstruction and residue; coarse uses top five bits
  // coarse and residue
  assign residue = st_reg.held.level -
                   {st_reg.held.level[AIN_W-1 -: COARSE_W], {(AIN_W-COARSE_W){1'b0}}};
  // overlap correction merge
  // Fine carries one redundant bit; its top bit corrects the coarse LSB
  assign merged = {st_reg.coarse, {(CODE_W-COARSE_W){1'b0}}} +
                  (CODE_W+1)'(st_reg.fine) - (CODE_W+1)'(1 << (FINE_W-2));

  ////////////////////////////////////////////////////////////////////////
  // Pipeline: edge N capture, N+1 estimates, N+2 correction, N+3 out
  always_comb begin
    st_next = st_reg;
    st_next.push = 1'b0;
    if (sample_edge) begin
      st_next.held = ain;
      st_next.coarse = st_reg.held.level[AIN_W-1 -: COARSE_W];
      st_next.fine = FINE_W'((residue >>> (AIN_W-CODE_W)) + (1 << (FINE_W-2)));
      st_next.s1_over  = st_reg.held.over;
      st_next.s1_under = st_reg.held.under;
      if (st_reg.s1_over)       st_next.s2 = '{code: CODE_POS_FS, oor: 1'b1};
      else if (st_reg.s1_under) st_next.s2 = '{code: CODE_NEG_FS, oor: 1'b1};
      else                      st_next.s2 = '{code: merged[CODE_W-1:0], oor: 1'b0};
      st_next.outw = st_reg.s2;
      if (st_reg.flush != FLUSH_DONE) st_next.flush = st_reg.flush + 3'h1;
      st_next.valid = (st_reg.flush >= FLUSH_DONE - 3'h1);
      st_next.push  = (st_reg.flush >= FLUSH_DONE - 3'h1);
    end
    if (clk_restart) begin
      st_next.flush = FLUSH_CNT_W0;
      st_next.valid = 1'b0;
    end
    // Words lost when the consumer stalls too long
    if (st_reg.push && !in_ready) st_next.ovf = 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)     st_reg <= '0;
    else if (ce) st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Output buffering toward capture logic
  sarp_fifo #(.WIDTH(CODE_W+1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .in_data   (st_reg.outw),
    .in_valid  (st_reg.push),
    .in_ready  (in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (fifo_ready)
  );

  assign sample_code_bits = st_reg.outw.code;
  assign out_of_range     = st_reg.outw.oor;
  assign code_valid       = st_reg.valid;
  assign fifo_overflow    = st_reg.ovf;
  assign fifo_word        = f_data;
  assign fifo_valid       = f_valid;
endmodule

// ### sarp_top_monitor.sv
/* Assertions on the sarp_top ports.
   Assumes one clock domain, rst async high, ce high while checked. */
`timescale 1ns/100ps
module sarp_top_monitor
  import sarp_pkg::*;
(
  input wire logic              ref_clk, rst, ce, sample_edge, clk_restart,
  input wire sarp_ain_t         ain,
  input wire logic [CODE_W-1:0] sample_code_bits,
  input wire logic              out_of_range, code_valid, fifo_valid, fifo_ready,
  input wire sarp_word_t        fifo_word,
  input wire logic              fifo_overflow
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire e = sample_edge && ce;
  // Word of edge N is checked after edge N+3
  hold_code_a: assert property ($changed(sample_code_bits) |-> $past(e))
    else $error("code moved without a sample edge");
  sat_pos_a: assert property (e && ain.over ##1 e [*3] |=> out_of_range && sample_code_bits == CODE_POS_FS)
    else $error("positive overdrive not saturated");
  sat_neg_a: assert property (e && ain.under ##1 e [*3] |=> out_of_range && sample_code_bits == CODE_NEG_FS)
    else $error("negative overdrive not saturated");
  in_range_a: assert property (e && !ain.over && !ain.under && ain.level[11] != ain.level[10]
    ##1 e [*3] |=> !out_of_range && sample_code_bits[9] == $past(ain.level[11], 4))
    else $error("in-range word flag or sign wrong");
  flush_low_a: assert property (clk_restart |=> !code_valid [*2])
    else $error("valid too soon after restart");
  flush_done_a: assert property (clk_restart ##1 (e && !clk_restart) [*4] |=> code_valid)
    else $error("valid missing after fourth edge");
  fifo_hold_a: assert property (fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_word))
    else $error("stalled fifo word not held");
  ovf_sticky_a: assert property (fifo_overflow |=> fifo_overflow)
    else $error("overflow flag dropped");
endmodule
bind sarp_top sarp_top_monitor sarp_top_monitor_inst (.ref_clk, .rst, .ce, .sample_edge,
  .clk_restart, .ain, .sample_code_bits, .out_of_range, .code_valid, .fifo_valid,
  .fifo_ready, .fifo_word, .fifo_overflow);

// ### sarp_capture.sv
/* Capture-side model: takes whole words from the FIFO, stalls on request.
   Assumes the bench moves stall away from the rising edge. */
`timescale 1ns/100ps
module sarp_capture
  import sarp_pkg::*;
(
  input  wire logic       ref_clk, rst, stall, fifo_valid,
  input  wire sarp_word_t fifo_word,
  output logic            fifo_ready,
  output int              rx_cnt
);
  assign fifo_ready = !stall;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) rx_cnt <= 0;
    else if (fifo_valid && fifo_ready) rx_cnt <= rx_cnt + 1;
  end
endmodule

// ### tb_sarp_top.sv
/* Bench for sarp_top: sample table, FIFO fill and restart flush.
   Assumes the capture model and the checker bind are compiled first. */
`timescale 1ns/100ps
module tb_sarp_top
  import sarp_pkg::*;
;
  typedef struct packed {sarp_ain_t a; sarp_word_t w;} sarp_row_t;
  logic ref_clk = 0, rst = 1, ce = 1, sample_edge = 0, clk_restart = 0, stall = 1;
  logic out_of_range, code_valid, fifo_valid, fifo_overflow, fifo_ready;
  logic [CODE_W-1:0] sample_code_bits;
  sarp_ain_t ain = '0;
  sarp_word_t fifo_word;
  int rx_cnt, error_cnt = 0, checked = 0;
  // Limits, overdrive both ways, straight back in range
  sarp_row_t rows [6] = '{{12'h07FF, 2'b00, 11'h03FE}, {12'h07FF, 2'b10, 11'h03FF},
    {12'h0800, 2'b00, 11'h0400}, {12'h0800, 2'b01, 11'h0401},
    {12'h0C00, 2'b00, 11'h0600}, {12'h0400, 2'b00, 11'h0200}};
  sarp_top sarp_top_inst (.ref_clk, .rst, .ce, .sample_edge, .clk_restart, .ain,
    .sample_code_bits, .out_of_range, .code_valid, .fifo_word, .fifo_valid,
    .fifo_ready, .fifo_overflow);
  sarp_capture sarp_capture_inst (.ref_clk, .rst, .stall, .fifo_valid, .fifo_word,
    .fifo_ready, .rx_cnt);
  task automatic chk(input string n, input logic [10:0] s, input logic [10:0] x);
    checked++;
    if (s !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic end_sim;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Clock and a watchdog far beyond the run length
  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin #2000; error_cnt++; end_sim; end
  initial begin
    repeat (2) @(negedge ref_clk);
    chk("reset", {code_valid, sample_code_bits}, 0);
    rst = 0;
    for (int j = 0; j < 10; j++) begin
      if (j >= 4) begin
        chk("oor", out_of_range, rows[j-4].w.oor);
        if (rows[j-4].w.oor) chk("code", sample_code_bits, rows[j-4].w.code);
        else chk("code", sample_code_bits, rows[j-4].w.code);
      end
      sample_edge = 1;
      ain = rows[j % 6].a;
      @(negedge ref_clk);
    end
    // Fill the FIFO past full while the far side stalls, then drain it
    repeat (20) @(negedge ref_clk);
    sample_edge = 0;
    chk("overflow", fifo_overflow, 1);
    // First pushed word is the sample of the first edge
    chk("fifo head", fifo_word, rows[0].w);
    stall = 0;
    repeat (40) @(negedge ref_clk);
    chk("drained", 11'(rx_cnt), 11'(FIFO_DEPTH));
    chk("empty", fifo_valid, 0);
    clk_restart = 1;
    @(negedge ref_clk);
    clk_restart = 0;
    sample_edge = 1;
    repeat (3) @(negedge ref_clk);
    chk("valid3", code_valid, 0);
    @(negedge ref_clk);
    chk("valid4", code_valid, 1);
    // Clock enable low must freeze the pipe against a new level
    ce = 0;
    ain = rows[4].a;
    repeat (4) @(negedge ref_clk);
    chk("frozen", sample_code_bits, CODE_NEG_FS);
    end_sim;
  end
endmodule
